// >>> rprc_pkg.sv
/*
 Package for the reference and pace routing control: widths, reset values,
 settling multipliers and the route states.
 Assumes nothing of its surroundings.
*/
package rprc_pkg;

  // ==========================================
  // Field widths and values
  localparam int SEL_W = 3;
  localparam int PIN_N = 6;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [7:0] SETTLE_MUL_ECG = 8'h05;
  localparam logic [7:0] SETTLE_MUL_STD = 8'h05;
  localparam logic [7:0] SETTLE_MUL_DBL = 8'h0a;
  localparam logic [2:0] DEC1_STD = 3'h4;
  localparam logic [2:0] DEC1_DBL = 3'h2;
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_RST = 24'h000000;

  // ==========================================
  // Reference terminal pin source
  typedef enum logic [1:0]
  {
    RPRC_TERM_AVG,
    RPRC_TERM_PACE,
    RPRC_TERM_OFF
  } rprc_term_t;

endpackage

// >>> rprc_top.sv
/*
 Reference and pace routing control: registers the pace amplifier input
 selection, pace output steering and shutdown, reference buffer selections,
 internal reference routing, and tracks filter settling after a step.
 Assumes configuration bits are synchronous to clk_sys and stable enough to
 be sampled each cycle; the analog switches follow the registered outputs.
*/
`timescale 1ns/100ps

module rprc_top
  import rprc_pkg::*;
#(
  parameter int NCH = 3
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [rprc_pkg::SEL_W-1:0] aux_amp_pos_sel,
  input wire logic [rprc_pkg::SEL_W-1:0] aux_amp_neg_sel,
  input wire logic pulse_to_drive_input_sel,
  input wire logic pulse_to_reference_pin_sel,
  input wire logic aux_amp_shutdown,
  input wire logic [rprc_pkg::SEL_W-1:0] ref_buffer_one_select,
  input wire logic [rprc_pkg::SEL_W-1:0] ref_buffer_two_select,
  input wire logic [rprc_pkg::SEL_W-1:0] ref_buffer_three_select,
  input wire logic avg_ref_internal_route,
  input wire logic pairwise_ref_internal_route,
  input wire logic [NCH-1:0] double_pace_rate,
  input wire logic [3:0] second_stage_decimation,
  input wire logic [7:0] third_stage_decimation,
  input wire logic step_event,
  output logic [5:0] aux_pos_pin_sw,
  output logic [5:0] aux_neg_pin_sw,
  output logic aux_amp_enable,
  output logic pace_to_drive_pin_sw,
  output logic drive_pos_to_reference_sw,
  output logic drive_pos_to_pin_sw,
  output logic pace_to_term_pin_sw,
  output logic avg_to_term_pin_sw,
  output logic [17:0] buf_pin_sw,
  output logic [2:0] buf_enable,
  output logic avg_to_in6_sw,
  output logic [2:0] pair_to_in456_sw,
  output logic route_illegal,
  output logic [NCH-1:0][2:0] first_stage_decimation,
  output logic main_unsettled,
  output logic [NCH-1:0] pulse_unsettled
);
  import rprc_pkg::*;

  // ==========================================
  // Reset release
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  logic rst_n;
  assign rst_n = rst_s2_r;

  // One-hot pin decode; code 0 selects no pin
  function automatic logic [5:0] pin_onehot(input logic [SEL_W-1:0] s);
    logic [5:0] v;
    v = 6'h00;
    if (s != SEL_NONE && s <= 3'h6)
      v[s - 3'h1] = 1'b1;
    return v;
  endfunction

  // ==========================================
  // Routing state
  logic [5:0] aux_pos_nxt, aux_neg_nxt;
  logic aux_en_nxt, p2d_nxt, dref_nxt, dpin_nxt, p2t_nxt, a2t_nxt;
  logic [17:0] buf_sw_nxt;
  logic [2:0] buf_en_nxt;
  logic a6_nxt, ill_nxt;
  logic [2:0] pair_nxt;
  rprc_term_t term_nxt;
  logic [5:0] b_oh [3];

  always_comb
  begin
    aux_pos_nxt = pin_onehot(aux_amp_pos_sel);
    aux_neg_nxt = pin_onehot(aux_amp_neg_sel);
    aux_en_nxt = !aux_amp_shutdown;
    p2d_nxt = pulse_to_drive_input_sel;
    dref_nxt = pulse_to_drive_input_sel;
    dpin_nxt = !pulse_to_drive_input_sel;
    b_oh[0] = pin_onehot(ref_buffer_one_select);
    b_oh[1] = pin_onehot(ref_buffer_two_select);
    b_oh[2] = pin_onehot(ref_buffer_three_select);
    buf_sw_nxt = {b_oh[2], b_oh[1], b_oh[0]};
    for (int i = 0; i < 3; i++)
      buf_en_nxt[i] = |b_oh[i];
    // Average exists only with at least one buffer running
    if (pulse_to_reference_pin_sel)
      term_nxt = RPRC_TERM_PACE;
    else if (|buf_en_nxt)
      term_nxt = RPRC_TERM_AVG;
    else
      term_nxt = RPRC_TERM_OFF;
    p2t_nxt = (term_nxt == RPRC_TERM_PACE);
    a2t_nxt = (term_nxt == RPRC_TERM_AVG);
    // Illegal pair: open both rather than short two outputs
    ill_nxt = avg_ref_internal_route && pairwise_ref_internal_route;
    a6_nxt = avg_ref_internal_route && !ill_nxt;
    pair_nxt = {3{pairwise_ref_internal_route && !ill_nxt}};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_pos_pin_sw <= 6'h00;
      aux_neg_pin_sw <= 6'h00;
      aux_amp_enable <= 1'b1;
      pace_to_drive_pin_sw <= 1'b0;
      drive_pos_to_reference_sw <= 1'b0;
      drive_pos_to_pin_sw <= 1'b1;
      pace_to_term_pin_sw <= 1'b0;
      avg_to_term_pin_sw <= 1'b0;
      buf_pin_sw <= 18'h00000;
      buf_enable <= 3'h0;
      avg_to_in6_sw <= 1'b0;
      pair_to_in456_sw <= 3'h0;
      route_illegal <= 1'b0;
    end
    else
    begin
      aux_pos_pin_sw <= aux_pos_nxt;
      aux_neg_pin_sw <= aux_neg_nxt;
      aux_amp_enable <= aux_en_nxt;
      pace_to_drive_pin_sw <= p2d_nxt;
      drive_pos_to_reference_sw <= dref_nxt;
      drive_pos_to_pin_sw <= dpin_nxt;
      pace_to_term_pin_sw <= p2t_nxt;
      avg_to_term_pin_sw <= a2t_nxt;
      buf_pin_sw <= buf_sw_nxt;
      buf_enable <= buf_en_nxt;
      avg_to_in6_sw <= a6_nxt;
      pair_to_in456_sw <= pair_nxt;
      route_illegal <= ill_nxt;
    end
  end

  // ==========================================
  // Decimation and settling
  logic [NCH-1:0][2:0] dec1_nxt;
  logic [CNT_W-1:0] main_cnt_r, main_cnt_nxt;
  logic [NCH-1:0][CNT_W-1:0] pls_cnt_r, pls_cnt_nxt;
  logic main_uns_nxt;
  logic [NCH-1:0] pls_uns_nxt;

  // Main length uses channel 0 first-stage ratio; per-channel third stage not modelled
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      dec1_nxt[c] = double_pace_rate[c] ? DEC1_DBL : DEC1_STD;
      if (step_event)
        pls_cnt_nxt[c] = CNT_W'((double_pace_rate[c] ? SETTLE_MUL_DBL : SETTLE_MUL_STD)
          * dec1_nxt[c] * second_stage_decimation);
      else if (pls_cnt_r[c] != CNT_RST)
        pls_cnt_nxt[c] = pls_cnt_r[c] - CNT_W'(1);
      else
        pls_cnt_nxt[c] = CNT_RST;
      pls_uns_nxt[c] = (pls_cnt_nxt[c] != CNT_RST);
    end
    if (step_event)
      main_cnt_nxt = CNT_W'(SETTLE_MUL_ECG * dec1_nxt[0] * second_stage_decimation
        * third_stage_decimation);
    else if (main_cnt_r != CNT_RST)
      main_cnt_nxt = main_cnt_r - CNT_W'(1);
    else
      main_cnt_nxt = CNT_RST;
    main_uns_nxt = (main_cnt_nxt != CNT_RST);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_cnt_r <= CNT_RST;
      pls_cnt_r <= '0;
      first_stage_decimation <= {NCH{DEC1_STD}};
      main_unsettled <= 1'b0;
      pulse_unsettled <= '0;
    end
    else
    begin
      main_cnt_r <= main_cnt_nxt;
      pls_cnt_r <= pls_cnt_nxt;
      first_stage_decimation <= dec1_nxt;
      main_unsettled <= main_uns_nxt;
      pulse_unsettled <= pls_uns_nxt;
    end
  end

endmodule

// >>> rprc_top_properties.sv
/* Port checker for rprc_top.
 Assumes bind to rprc_top; outputs lag inputs by one cycle. */
`timescale 1ns/100ps
module rprc_top_properties #(parameter int NCH = 3) (
  input wire logic clk_sys, resetn, step_event, aux_amp_shutdown, aux_amp_enable, main_unsettled,
  input wire logic pulse_to_drive_input_sel, pulse_to_reference_pin_sel, pace_to_drive_pin_sw,
  input wire logic drive_pos_to_reference_sw, drive_pos_to_pin_sw, pace_to_term_pin_sw, avg_to_term_pin_sw,
  input wire logic avg_ref_internal_route, pairwise_ref_internal_route, avg_to_in6_sw, route_illegal,
  input wire logic [2:0] aux_amp_pos_sel, ref_buffer_one_select, pair_to_in456_sw, buf_enable,
  input wire logic [5:0] aux_pos_pin_sw,
  input wire logic [NCH-1:0] pulse_unsettled
);
  // ==========================================
  // Skip the edges while the reset copy is still low
  logic [2:0] live_r;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) live_r <= 3'h0;
    else if (live_r != 3'h4) live_r <= live_r + 3'h1;
  wire ok = (live_r == 3'h4);
  function automatic logic [5:0] oh(logic [2:0] s);
    return (s >= 3'h1 && s <= 3'h6) ? 6'h01 << (s - 3'h1) : 6'h00;
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_step; ok && step_event; endsequence
  a_amp_shutdown: assert property (ok |-> aux_amp_enable == !$past(aux_amp_shutdown))
    else $error("amp enable wrong");
  a_drive_route: assert property (ok |-> {pace_to_drive_pin_sw, drive_pos_to_reference_sw, drive_pos_to_pin_sw}
    == {$past(pulse_to_drive_input_sel), $past(pulse_to_drive_input_sel), !$past(pulse_to_drive_input_sel)})
    else $error("drive route wrong");
  a_term_pace: assert property (ok && $past(pulse_to_reference_pin_sel) |-> pace_to_term_pin_sw && !avg_to_term_pin_sw)
    else $error("term pin wrong");
  a_pos_select: assert property (ok |-> aux_pos_pin_sw == oh($past(aux_amp_pos_sel)))
    else $error("pos select wrong");
  a_buffer_hiz: assert property (ok |-> buf_enable[0] == |oh($past(ref_buffer_one_select)))
    else $error("buffer enable wrong");
  a_avg_in6: assert property (ok |-> avg_to_in6_sw == ($past(avg_ref_internal_route) && !$past(pairwise_ref_internal_route)))
    else $error("avg route wrong");
  a_pair_route: assert property (ok |-> pair_to_in456_sw == {3{$past(pairwise_ref_internal_route) && !$past(avg_ref_internal_route)}})
    else $error("pair route wrong");
  a_illegal_flag: assert property (ok |-> route_illegal == ($past(avg_ref_internal_route) && $past(pairwise_ref_internal_route)))
    else $error("illegal flag wrong");
  a_main_settle: assert property (s_step |=> main_unsettled [*8])
    else $error("main settle short");
  a_pulse_settle: assert property (s_step |=> pulse_unsettled[0] [*8])
    else $error("pulse settle short");
endmodule
bind rprc_top rprc_top_properties #(.NCH(NCH)) i_chk (.*);

// >>> tb_top.sv
/* Self-checking bench for rprc_top.
 Assumes one-cycle output lag and the two-flop reset release. */
`timescale 1ns/100ps
module tb_top;
  import rprc_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, step_event = 1'b0, aux_amp_shutdown = 1'b0;
  logic pulse_to_drive_input_sel = 1'b0, pulse_to_reference_pin_sel = 1'b0;
  logic avg_ref_internal_route = 1'b0, pairwise_ref_internal_route = 1'b0;
  logic [2:0] aux_amp_pos_sel = 3'h0, aux_amp_neg_sel = 3'h0, ref_buffer_one_select = 3'h0;
  logic [2:0] ref_buffer_two_select = 3'h0, ref_buffer_three_select = 3'h0, double_pace_rate = 3'h2;
  logic [3:0] second_stage_decimation = 4'h4;
  logic [7:0] third_stage_decimation = 8'h04;
  logic [5:0] aux_pos_pin_sw, aux_neg_pin_sw;
  logic aux_amp_enable, pace_to_drive_pin_sw, drive_pos_to_reference_sw, drive_pos_to_pin_sw;
  logic pace_to_term_pin_sw, avg_to_term_pin_sw, avg_to_in6_sw, route_illegal, main_unsettled;
  logic [17:0] buf_pin_sw;
  logic [2:0] buf_enable, pair_to_in456_sw, pulse_unsettled;
  logic [2:0][2:0] first_stage_decimation;
  int n_mismatch = 0, num_checks = 0;
  rprc_top i_dut (.*);
  task automatic chk(string what, logic [17:0] seen, logic [17:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [5:0] oh(logic [2:0] s);
    return (s >= 3'h1 && s <= 3'h6) ? 6'h01 << (s - 3'h1) : 6'h00;
  endfunction
  initial forever #10 clk_sys = ~clk_sys;
  // ==========================================
  // Whole run is about 500 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    int n_m, n_p, n_q;
    logic [3:0] c;
    logic [2:0] b2, b3;
    repeat (4) @(posedge clk_sys);
    #1 chk("reset", {aux_amp_enable, drive_pos_to_pin_sw, avg_to_term_pin_sw, buf_enable, first_stage_decimation}, {6'h30, 9'h124});
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("idle", {pace_to_term_pin_sw, avg_to_in6_sw, pair_to_in456_sw, route_illegal}, 6'h00);
    chk("first stage", first_stage_decimation, 9'h114);
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      b2 = c[2:0] ^ 3'h5;
      b3 = c[2:0] + 3'h3;
      @(posedge clk_sys);
      {pairwise_ref_internal_route, avg_ref_internal_route, pulse_to_reference_pin_sel} <= c[3:1];
      pulse_to_drive_input_sel <= c[0];
      aux_amp_shutdown <= ~c[0];
      aux_amp_pos_sel <= c[2:0];
      aux_amp_neg_sel <= b2;
      ref_buffer_one_select <= c[2:0];
      ref_buffer_two_select <= b2;
      ref_buffer_three_select <= b3;
      repeat (2) @(posedge clk_sys);
      #1 chk("pace inputs", {aux_pos_pin_sw, aux_neg_pin_sw}, {oh(c[2:0]), oh(b2)});
      chk("buffer pins", buf_pin_sw, {oh(b3), oh(b2), oh(c[2:0])});
      chk("buffer enable", buf_enable, {|oh(b3), |oh(b2), |oh(c[2:0])});
      chk("pace amp", {aux_amp_enable, pace_to_drive_pin_sw, drive_pos_to_reference_sw, drive_pos_to_pin_sw}, {c[0], c[0], c[0], !c[0]});
      chk("term pin", {pace_to_term_pin_sw, avg_to_term_pin_sw}, {c[1], !c[1] && |{oh(b3), oh(b2), oh(c[2:0])}});
      chk("internal", {avg_to_in6_sw, pair_to_in456_sw, route_illegal}, {c[2] && !c[3], {3{c[3] && !c[2]}}, c[3] && c[2]});
    end
    $display("routing test done");
    @(posedge clk_sys);
    step_event <= 1'b1;
    @(posedge clk_sys);
    step_event <= 1'b0;
    n_m = 0;
    n_p = 0;
    n_q = 0;
    // Count from the edge that takes the step, so the first flagged cycle is seen
    repeat (400)
    begin
      #1;
      n_m += (main_unsettled === 1'b1);
      n_p += (pulse_unsettled[0] === 1'b1);
      n_q += (pulse_unsettled[1] === 1'b1);
      @(posedge clk_sys);
    end
    chk("main settle", 18'(n_m), 18'(5 * 4 * 4 * 4));
    chk("pulse std", 18'(n_p), 18'(5 * 4 * 4));
    chk("pulse dbl", 18'(n_q), 18'(10 * 2 * 4));
    $display("settling test done");
    wrap_up();
  end
endmodule
